//--- design/fer_codec.sv
// Event record encoder and decoder for virtual sensor FIFO records.
// Function
// - Byte zero is the eight-bit sensor identifier.
// - Quaternion components signed 16-bit, low byte first.
// - Quaternion order X, Y, Z, W.
// - Bytes nine, ten carry unsigned heading accuracy.
// - Game rotation heading accuracy always zero.
// - Rotation heading accuracy clamped 0.0873 to pi.
// - Euler record carries heading, pitch, roll.
// - Three-axis record carries X, Y, Z.
// - Pass-through forwards samples unmodified.
// - Raw acceleration equals pass-through unless filter enabled.
// - Raw rate equals pass-through unless filter enabled.
// - Corrected acceleration subtracts offset; offset reported.
// - Corrected rate subtracts zero-rate offset.
// - Corrected calibration rating zero to three is latched in calTag_r but not sent in the record.
// - Rotation records 11 bytes, others 7.
// - Acceleration range is one of four codes.
`timescale 1ns/1ns
`default_nettype none
module fer_codec
    import fer_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Encoder request.
    input wire logic encValid,
    output logic encReady,
    input wire fer_fmt_e encFmt,
    input wire fer_src_e encSrc,
    input wire logic [BYTE_W-1:0] encSensorId,
    input wire logic [WORD_W-1:0] encW0,
    input wire logic [WORD_W-1:0] encW1,
    input wire logic [WORD_W-1:0] encW2,
    input wire logic [WORD_W-1:0] encW3,
    input wire logic [WORD_W-1:0] encW4,
    input wire logic [WORD_W-1:0] encOff0,
    input wire logic [WORD_W-1:0] encOff1,
    input wire logic [WORD_W-1:0] encOff2,
    input wire logic [1:0] encCalAcc,
    input wire logic lowPassEn,
    // Encoded byte stream out.
    output logic txValid,
    input wire logic txReady,
    output logic [BYTE_W-1:0] txData,
    // Byte stream in for decoding.
    input wire logic rxValid,
    input wire logic [BYTE_W-1:0] rxData,
    input wire logic rxIsRotation,
    // Decoded record.
    output logic recValid,
    output logic [BYTE_W-1:0] recSensorId,
    output logic [WORD_W-1:0] recW0,
    output logic [WORD_W-1:0] recW1,
    output logic [WORD_W-1:0] recW2,
    output logic [WORD_W-1:0] recW3,
    output logic [WORD_W-1:0] recW4,
    // Range code for acceleration-type scaling.
    input wire logic [1:0] accRangeSel,
    output logic [15:0] accCountsPerG
);
    typedef enum logic [1:0] {
        ENC_IDLE,
        ENC_SEND
    } fer_enc_e;

    fer_enc_e encState_r;
    fer_enc_e encState_nxt;
    logic [BYTE_W-1:0] frame_r [11];
    logic [CNT_W-1:0] encIdx_r;
    logic [CNT_W-1:0] encLen_r;
    logic [WORD_W-1:0] lpState_r [3];
    logic [WORD_W-1:0] procW [3];
    logic [WORD_W-1:0] hacc;
    logic [1:0] calOut;
    logic [CNT_W-1:0] lenSel;
    logic fifoInReady;
    logic fifoInValid;
    logic [BYTE_W-1:0] fifoInData;
    wire isRot = (encFmt == FMT_ROTATION) || (encFmt == FMT_GAME_ROTATION);
    wire takeReq = encValid && (encState_r == ENC_IDLE);
    wire lastByte = fifoInValid && fifoInReady && (encIdx_r == encLen_r - 1'b1);

    assign encReady = (encState_r == ENC_IDLE);

    // pass-through and raw processing with optional low pass.
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_axis
            logic [WORD_W-1:0] inW;
            logic [WORD_W-1:0] avgW;
            assign inW = (g == 0) ? encW0 : (g == 1) ? encW1 : encW2;
            assign avgW = WORD_W'(({inW[WORD_W-1], inW} + {lpState_r[g][WORD_W-1],
                lpState_r[g]}) >>> 1);
            assign procW[g] = (encSrc == SRC_RAW && lowPassEn) ? avgW :
                (encSrc == SRC_CORRECTED) ? WORD_W'(inW - ((g == 0) ? encOff0 :
                (g == 1) ? encOff1 : encOff2)) :
                (encSrc == SRC_OFFSET) ? ((g == 0) ? encOff0 : (g == 1) ? encOff1 :
                encOff2) : inW;
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    lpState_r[g] <= WORD_ZERO;
                end else if (takeReq && encSrc == SRC_RAW) begin
                    lpState_r[g] <= procW[g];
                end
            end
        end
    endgenerate

    // zero for game rotation, clamp for full rotation.
    assign hacc = (encFmt == FMT_GAME_ROTATION) ? HACC_ZERO :
        (encW4 < HACC_MIN) ? HACC_MIN : (encW4 > HACC_MAX) ? HACC_MAX : encW4;

    // rating only on corrected records, otherwise not calibrated.
    assign calOut = (encSrc == SRC_CORRECTED) ? encCalAcc : CAL_NONE;

    // record lengths including the identifier byte.
    assign lenSel = isRot ? LEN_ROTATION : LEN_THREE;

    // range code to counts per g.
    assign accCountsPerG = (accRangeSel == RANGE_2K) ? CPG_2K :
        (accRangeSel == RANGE_4K) ? CPG_4K :
        (accRangeSel == RANGE_8K) ? CPG_8K : CPG_16K;

    always_comb begin
        encState_nxt = encState_r;
        unique case (encState_r)
            ENC_IDLE: begin
                if (encValid) begin
                    encState_nxt = ENC_SEND;
                end
            end
            ENC_SEND: begin
                if (lastByte) begin
                    encState_nxt = ENC_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            encState_r <= ENC_IDLE;
            encIdx_r <= '0;
            encLen_r <= LEN_THREE;
        end else begin
            encState_r <= encState_nxt;
            if (takeReq) begin
                encIdx_r <= '0;
                encLen_r <= lenSel;
            end else if (fifoInValid && fifoInReady) begin
                encIdx_r <= encIdx_r + 1'b1;
            end
        end
    end

    // identifier at byte zero; words low byte first in order.
    always_ff @(posedge clk) begin
        if (takeReq) begin
            frame_r[0] <= encSensorId;
            frame_r[1] <= isRot || encFmt == FMT_EULER ? encW0[7:0] : procW[0][7:0];
            frame_r[2] <= isRot || encFmt == FMT_EULER ? encW0[15:8] : procW[0][15:8];
            frame_r[3] <= isRot || encFmt == FMT_EULER ? encW1[7:0] : procW[1][7:0];
            frame_r[4] <= isRot || encFmt == FMT_EULER ? encW1[15:8] : procW[1][15:8];
            frame_r[5] <= isRot || encFmt == FMT_EULER ? encW2[7:0] : procW[2][7:0];
            frame_r[6] <= isRot || encFmt == FMT_EULER ? encW2[15:8] : procW[2][15:8];
            frame_r[7] <= encW3[7:0];
            frame_r[8] <= encW3[15:8];
            // heading accuracy in bytes nine and ten.
            frame_r[9] <= hacc[7:0];
            frame_r[10] <= hacc[15:8];
        end
    end

    logic [1:0] calTag_r;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            calTag_r <= CAL_NONE;
        end else if (takeReq) begin
            calTag_r <= calOut;
        end
    end

    assign fifoInValid = (encState_r == ENC_SEND);
    assign fifoInData = frame_r[encIdx_r];

    fer_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData(fifoInData),
        .outValid(txValid),
        .outReady(txReady),
        .outData(txData)
    );

    // Decoder side.
    logic [CNT_W-1:0] rxIdx_r;
    logic rxRot_r;
    logic [BYTE_W-1:0] rxBuf_r [11];
    logic recValid_r;
    wire rxFirst = (rxIdx_r == POS_ID);
    wire rxRotNow = rxFirst ? rxIsRotation : rxRot_r;
    wire [CNT_W-1:0] rxLastPos = rxRotNow ? POS_LAST_ROT : POS_LAST_THREE;
    wire rxDone = rxValid && (rxIdx_r == rxLastPos);

    always_ff @(posedge clk) begin
        if (rxValid) begin
            rxBuf_r[rxIdx_r] <= rxData;
        end
    end

    // one-cycle strobe after the last byte of the record.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rxIdx_r <= POS_ID;
            rxRot_r <= 1'b0;
            recValid_r <= 1'b0;
        end else begin
            recValid_r <= rxDone;
            if (rxValid) begin
                rxRot_r <= rxRotNow;
                rxIdx_r <= rxDone ? POS_ID : rxIdx_r + 1'b1;
            end
        end
    end

    logic [BYTE_W-1:0] recId_r;
    logic [WORD_W-1:0] recW_r [5];
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            recId_r <= '0;
            for (int i = 0; i < 5; i++) begin
                recW_r[i] <= WORD_ZERO;
            end
        end else if (rxDone) begin
            recId_r <= rxBuf_r[0];
            recW_r[0] <= {rxBuf_r[2], rxBuf_r[1]};
            recW_r[1] <= {rxBuf_r[4], rxBuf_r[3]};
            recW_r[2] <= rxRotNow ? {rxBuf_r[6], rxBuf_r[5]} : {rxData, rxBuf_r[5]};
            recW_r[3] <= rxRotNow ? {rxBuf_r[8], rxBuf_r[7]} : WORD_ZERO;
            recW_r[4] <= rxRotNow ? {rxData, rxBuf_r[9]} : WORD_ZERO;
        end
    end

    assign recValid = recValid_r;
    assign recSensorId = recId_r;
    assign recW0 = recW_r[0];
    assign recW1 = recW_r[1];
    assign recW2 = recW_r[2];
    assign recW3 = recW_r[3];
    assign recW4 = recW_r[4];
endmodule : fer_codec
`default_nettype wire

//--- design/fer_pkg.sv
// Constants and types shared by the event record codec.
package fer_pkg;
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int CNT_W = 4;
    localparam logic [3:0] POS_ID = 4'h0;
    localparam logic [3:0] POS_LAST_QUAT = 4'h8;
    localparam logic [3:0] POS_LAST_THREE = 4'h6;
    localparam logic [3:0] LEN_ROTATION = 4'hb;
    localparam logic [3:0] LEN_THREE = 4'h7;
    localparam logic [3:0] POS_LAST_ROT = 4'ha;
    // Heading accuracy bounds in 2^-14 radian units: 0.0873 and pi.
    localparam logic [15:0] HACC_MIN = 16'h0596;
    localparam logic [15:0] HACC_MAX = 16'hc910;
    localparam logic [15:0] HACC_ZERO = 16'h0000;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [1:0] CAL_NONE = 2'h0;
    localparam logic [1:0] CAL_LOW = 2'h1;
    localparam logic [1:0] CAL_MED = 2'h2;
    localparam logic [1:0] CAL_HIGH = 2'h3;
    // Acceleration range codes: 2048, 4096, 8192, 16384 counts per g.
    localparam logic [1:0] RANGE_2K = 2'h0;
    localparam logic [1:0] RANGE_4K = 2'h1;
    localparam logic [1:0] RANGE_8K = 2'h2;
    localparam logic [1:0] RANGE_16K = 2'h3;
    localparam logic [15:0] CPG_2K = 16'h0800;
    localparam logic [15:0] CPG_4K = 16'h1000;
    localparam logic [15:0] CPG_8K = 16'h2000;
    localparam logic [15:0] CPG_16K = 16'h4000;
    typedef enum logic [1:0] {
        FMT_ROTATION,
        FMT_GAME_ROTATION,
        FMT_EULER,
        FMT_THREE_AXIS
    } fer_fmt_e;
    typedef enum logic [2:0] {
        SRC_PASS,
        SRC_RAW,
        SRC_CORRECTED,
        SRC_OFFSET,
        SRC_DIRECT
    } fer_src_e;
endpackage : fer_pkg

//--- design/fer_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/1ns
`default_nettype none
module fer_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Fill side.
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side.
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wrPtr_r;
    logic [AW-1:0] rdPtr_r;
    logic [AW:0] count_r;
    wire push = inValid && inReady;
    wire pop = outValid && outReady;
    assign inReady = (count_r != (AW+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign outData = mem_r[rdPtr_r];
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wrPtr_r] <= inData;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wrPtr_r <= (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_r <= (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : fer_fifo
`default_nettype wire

//--- verification/fer_host_model.sv
// Host model that drains the encoded byte stream and keeps the last 256 bytes.
`timescale 1ns/1ns
`default_nettype none
module fer_host_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Byte stream from the device.
    input wire logic txValid,
    output logic txReady,
    input wire logic [7:0] txData,
    // Stall request from the bench.
    input wire logic stall
);
    logic [7:0] buf_r [0:255];
    int cnt;
    assign txReady = !stall;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt <= 0;
        end else if (txValid && txReady) begin
            buf_r[cnt[7:0]] <= txData;
            cnt <= cnt + 1;
        end
    end
endmodule : fer_host_model
`default_nettype wire

//--- verification/fer_codec_asserts.sv
// Checker for the codec ports.
`timescale 1ns/1ns
`default_nettype none
module fer_codec_asserts
    import fer_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic encValid,
    input wire logic encReady,
    input wire logic txValid,
    input wire logic txReady,
    input wire logic [BYTE_W-1:0] txData,
    input wire logic rxValid,
    input wire logic rxIsRotation,
    input wire logic recValid,
    input wire logic [WORD_W-1:0] recW0,
    input wire logic [WORD_W-1:0] recW3,
    input wire logic [WORD_W-1:0] recW4,
    input wire logic [1:0] accRangeSel,
    input wire logic [15:0] accCountsPerG
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [3:0] pos_r;
    logic rot_r;
    wire curRot = (pos_r == 4'h0) ? rxIsRotation : rot_r;
    wire lastHit = rxValid && (pos_r == (curRot ? 4'ha : 4'h6));
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pos_r <= 4'h0;
            rot_r <= 1'b0;
        end else if (rxValid) begin
            pos_r <= lastHit ? 4'h0 : pos_r + 4'h1;
            rot_r <= curRot;
        end
    end
    property p_rst;
        @(posedge clk) disable iff (1'b0) sys_rst |=> !recValid && !txValid && encReady;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle after reset");
    property p_take; encValid && encReady |=> !encReady; endproperty
    a_take: assert property (p_take) else $error("encoder ready after take");
    property p_first; encValid && encReady |-> ##2 txValid; endproperty
    a_first: assert property (p_first) else $error("first byte late");
    property p_hold; txValid && !txReady |=> txValid && $stable(txData); endproperty
    a_hold: assert property (p_hold) else $error("stalled byte changed");
    property p_range; 1'b1 |-> accCountsPerG == (16'h0800 << accRangeSel); endproperty
    a_range: assert property (p_range) else $error("wrong counts per g");
    property p_last; lastHit |=> recValid; endproperty
    a_last: assert property (p_last) else $error("record strobe missing");
    property p_pulse; recValid |-> $past(lastHit); endproperty
    a_pulse: assert property (p_pulse) else $error("stray record strobe");
    property p_short; recValid && !rot_r |-> recW3 == 16'h0000 && recW4 == 16'h0000; endproperty
    a_short: assert property (p_short) else $error("short record extra words");
    property p_keep; !recValid ##1 !recValid |-> $stable(recW0); endproperty
    a_keep: assert property (p_keep) else $error("record field changed");
    c_rot: cover property (recValid && rot_r);
    c_stall: cover property (txValid && !txReady);
    c_busy: cover property (encValid && !encReady);
endmodule : fer_codec_asserts
bind fer_codec fer_codec_asserts u_chk (.clk(clk), .sys_rst(sys_rst), .encValid(encValid),
    .encReady(encReady), .txValid(txValid), .txReady(txReady), .txData(txData),
    .rxValid(rxValid), .rxIsRotation(rxIsRotation), .recValid(recValid), .recW0(recW0),
    .recW3(recW3), .recW4(recW4), .accRangeSel(accRangeSel), .accCountsPerG(accCountsPerG));
`default_nettype wire

//--- verification/fer_codec_test.sv
// Self-checking bench for the event record codec.
`timescale 1ns/1ns
`default_nettype none
module fer_codec_test;
    import fer_pkg::*;
    logic clk = 0, sys_rst = 1, encValid = 0, lowPassEn = 0, rxValid = 0, rxIsRotation = 0;
    logic stall = 0, txValid, txReady, encReady, recValid;
    fer_fmt_e encFmt = FMT_ROTATION;
    fer_src_e encSrc = SRC_DIRECT;
    logic [7:0] encSensorId = 8'h00, rxData = 8'h00, txData, recSensorId;
    logic [15:0] encW0 = 0, encW1 = 0, encW2 = 0, encW3 = 0, encW4 = 0;
    logic [15:0] encOff0 = 0, encOff1 = 0, encOff2 = 0, accCountsPerG;
    logic [15:0] recW0, recW1, recW2, recW3, recW4;
    logic [1:0] encCalAcc = 2'h3, accRangeSel = 2'h0;
    int errors = 0, checks = 0;
    always #20 clk = ~clk;
    fer_codec DUT (.clk(clk), .sys_rst(sys_rst), .encValid(encValid), .encReady(encReady),
        .encFmt(encFmt), .encSrc(encSrc), .encSensorId(encSensorId), .encW0(encW0),
        .encW1(encW1), .encW2(encW2), .encW3(encW3), .encW4(encW4), .encOff0(encOff0),
        .encOff1(encOff1), .encOff2(encOff2), .encCalAcc(encCalAcc), .lowPassEn(lowPassEn),
        .txValid(txValid), .txReady(txReady), .txData(txData), .rxValid(rxValid),
        .rxData(rxData), .rxIsRotation(rxIsRotation), .recValid(recValid),
        .recSensorId(recSensorId), .recW0(recW0), .recW1(recW1), .recW2(recW2), .recW3(recW3),
        .recW4(recW4), .accRangeSel(accRangeSel), .accCountsPerG(accCountsPerG));
    fer_host_model host (.clk(clk), .sys_rst(sys_rst), .txValid(txValid), .txReady(txReady),
        .txData(txData), .stall(stall));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic results;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    // Encodes one record and compares the bytes the host received.
    task automatic encChk(input int n, input logic [15:0] e[5]);
        int base, i;
        base = host.cnt;
        encValid = 1;
        @(posedge clk); #1;
        encValid = 0;
        for (i = 0; i < 400 && host.cnt < base + n; i++) @(posedge clk);
        repeat (3) @(posedge clk); #1;
        chk(host.cnt - base, n);
        chk({8'h00, host.buf_r[base]}, {8'h00, encSensorId});
        for (i = 0; i < (n - 1) / 2; i++) begin
            chk({host.buf_r[base+2*i+2], host.buf_r[base+2*i+1]}, e[i]);
        end
    endtask : encChk
    task automatic tRotation;
        encFmt = FMT_ROTATION;
        encSensorId = 8'h22;
        {encW0, encW1, encW2, encW3, encW4} = {16'h1234, 16'hc001, 16'h7fff, 16'h8000, 16'h2000};
        stall = 1;
        fork
            begin repeat (20) @(posedge clk); #1; stall = 0; end
            encChk(11, '{16'h1234, 16'hc001, 16'h7fff, 16'h8000, 16'h2000});
        join
        encW4 = 16'h0001;
        encChk(11, '{16'h1234, 16'hc001, 16'h7fff, 16'h8000, HACC_MIN});
        encW4 = 16'hffff;
        encChk(11, '{16'h1234, 16'hc001, 16'h7fff, 16'h8000, HACC_MAX});
        encFmt = FMT_GAME_ROTATION;
        encW4 = 16'h2000;
        encChk(11, '{16'h1234, 16'hc001, 16'h7fff, 16'h8000, HACC_ZERO});
        $display("test rotation done");
    endtask : tRotation
    task automatic tSources;
        encFmt = FMT_EULER;
        encSrc = SRC_DIRECT;
        {encW0, encW1, encW2} = {16'h0102, 16'hfffe, 16'h4000};
        encChk(7, '{16'h0102, 16'hfffe, 16'h4000, 0, 0});
        encFmt = FMT_THREE_AXIS;
        encSrc = SRC_PASS;
        encChk(7, '{16'h0102, 16'hfffe, 16'h4000, 0, 0});
        encSrc = SRC_RAW;
        encChk(7, '{16'h0102, 16'hfffe, 16'h4000, 0, 0});
        {encOff0, encOff1, encOff2} = {16'h0002, 16'h0003, 16'hffff};
        encSrc = SRC_CORRECTED;
        encChk(7, '{16'h0100, 16'hfffb, 16'h4001, 0, 0});
        encSrc = SRC_OFFSET;
        encChk(7, '{16'h0002, 16'h0003, 16'hffff, 0, 0});
        lowPassEn = 1;
        encSrc = SRC_RAW;
        {encW0, encW1, encW2} = {16'h0104, 16'h0000, 16'h4002};
        encChk(7, '{16'h0103, 16'hffff, 16'h4001, 0, 0});
        lowPassEn = 0;
        $display("test sources done");
    endtask : tSources
    // Feeds a record into the decoder and checks the fields.
    task automatic decChk(input logic rot, input logic [7:0] b[11]);
        int i;
        for (i = 0; i < (rot ? 11 : 7); i++) begin
            rxValid = 1;
            rxData = b[i];
            rxIsRotation = (i == 0) ? rot : 1'b0;
            @(posedge clk); #1;
        end
        rxValid = 0;
        chk({15'h0000, recValid}, 16'h0001);
        chk({8'h00, recSensorId}, {8'h00, b[0]});
        chk(recW0, {b[2], b[1]});
        chk(recW1, {b[4], b[3]});
        chk(recW2, {b[6], b[5]});
        chk(recW3, rot ? {b[8], b[7]} : 16'h0000);
        chk(recW4, rot ? {b[10], b[9]} : 16'h0000);
        @(posedge clk); #1;
        chk({15'h0000, recValid}, 16'h0000);
    endtask : decChk
    task automatic tDecode;
        int i;
        decChk(1, '{8'h22, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88, 8'h99, 8'haa});
        decChk(0, '{8'h04, 8'h01, 8'h80, 8'h02, 8'h03, 8'hfe, 8'hff, 0, 0, 0, 0});
        for (i = 0; i < 4; i++) begin
            accRangeSel = i[1:0];
            #1;
            chk(accCountsPerG, 16'h0800 << i);
        end
        $display("test decode done");
    endtask : tDecode
    initial begin
        repeat (5) @(posedge clk);
        #1;
        sys_rst = 0;
        tRotation();
        tSources();
        tDecode();
        results();
    end
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        results();
    end
endmodule : fer_codec_test
`default_nettype wire
